// file: design/urd_pkg.sv
// Package for the ring-buffered serial port: register map, fields, reset values.
// Assumes a 32-bit APB slave port and a single system clock.
`default_nettype none
package urd_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFF_CTRL    = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_BAUD    = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_RXBASE  = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_RXSIZE  = 12'h00C;
  localparam logic [ADDR_W-1:0] OFF_TXBASE  = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_TXSIZE  = 12'h014;
  localparam logic [ADDR_W-1:0] OFF_RXCOUNT = 12'h018;
  localparam logic [ADDR_W-1:0] OFF_RXDATA  = 12'h01C;
  localparam logic [ADDR_W-1:0] OFF_TXQUEUE = 12'h020;
  localparam logic [ADDR_W-1:0] OFF_TXSTAT  = 12'h024;
  localparam logic [ADDR_W-1:0] OFF_STRREAD = 12'h028;
  localparam logic [ADDR_W-1:0] OFF_STATUS  = 12'h02C;
  localparam logic [ADDR_W-1:0] OFF_MASK    = 12'h030;
  localparam logic [ADDR_W-1:0] OFF_RXRAW   = 12'h034;
  // Control register bits
  localparam int unsigned CT_ENABLE = 0;
  localparam int unsigned CT_TXIE   = 1;
  localparam int unsigned CT_PAREN  = 2;
  localparam int unsigned CT_PARODD = 3;
  localparam int unsigned CT_STOP2  = 4;
  localparam int unsigned CT_SEVEN  = 5;
  localparam int unsigned CT_RTS    = 6;
  localparam int unsigned CT_CTS    = 7;
  localparam int unsigned CT_SHUT   = 8;
  // Status / mask bits
  localparam int unsigned EV_RXBYTE = 0;
  localparam int unsigned EV_TXDONE = 1;
  localparam int unsigned EV_CRSEEN = 2;
  localparam int unsigned EV_W      = 3;
  localparam logic [15:0] BAUD_RESET = 16'h0008;
  localparam logic [7:0]  CR_BYTE    = 8'h0D;
  localparam int unsigned OVERSAMPLE = 16;
  localparam int unsigned MID_SAMPLE = 8;
  typedef enum logic [2:0] {URD_IDLE, URD_START, URD_DATA, URD_PAR, URD_STOP} urd_state_e;
endpackage
`default_nettype wire

// file: design/urd_baud_gen.sv
// Oversampling tick generator: clock / divisor gives sixteen ticks per bit.
// Assumes divisor is static while the port runs.
`default_nettype none
module urd_baud_gen import urd_pkg::*; (
  input  wire logic        clk_sys,  // System clock
  input  wire logic        reset_n,  // Async reset
  input  wire logic        run,      // Counter runs
  input  wire logic [15:0] divisor,  // Clocks per 1/16 bit
  output logic             tick      // 1/16-bit strobe
);
  logic [15:0] cnt_q;
  wire         wrap = (cnt_q + 16'h0001 >= divisor);
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) cnt_q <= '0;
    else if (!run || wrap) cnt_q <= '0;
    else cnt_q <= cnt_q + 16'h0001;
  end
  assign tick = run && wrap; // [RULE15]
endmodule
`default_nettype wire

// file: design/urd_ring_ram.sv
// Byte ring storage: one write port, one combinational read port.
// Assumes caller keeps both addresses inside the array.
`default_nettype none
module urd_ring_ram #(
  parameter int unsigned AW = 8
) (
  input  wire logic          clk_sys,  // System clock
  input  wire logic          we,       // Write strobe
  input  wire logic [AW-1:0] waddr,    // Write address
  input  wire logic [7:0]    wdata,    // Write byte
  input  wire logic [AW-1:0] raddr,    // Read address
  output logic      [7:0]    rdata     // Read byte
);
  logic [7:0] mem [0:(1<<AW)-1];
  always_ff @(posedge clk_sys) begin
    if (we) mem[waddr] <= wdata;
  end
  assign rdata = mem[raddr];
endmodule
`default_nettype wire

// file: design/urd_serial_port.sv
// Serial port with a receive ring and a transmit ring held in local memory.
// Assumes an APB master on clk_sys and an asynchronous RS-232 partner on rxd/txd.
// What this block does
// [RULE1] After reset the frame is eight data bits, one stop, no parity.
// [RULE2] Each received byte goes at the write index, wrapping; full ring overwrites silently.
// [RULE3] Reception runs until reset, an explicit port shutdown or clearing the control enable bit.
// [RULE4] Receive count is write index minus read index; zero means empty.
// [RULE5] Reading data returns the byte at the read index, then advances it.
// [RULE6] Transmit fetches bytes while indices differ; equal indices clear its enable.
// [RULE7] When all queued bytes are sent the busy flag clears.
// [RULE8] Queuing a byte sets the transmit enable, so bytes queued while it is off are still sent.
// [RULE9] Host leaves the transmit ring alone once transmission is enabled.
// [RULE10] Queuing one byte stores it when the ring has room; a full ring drops it and TXSTAT bit 1 shows full.
// [RULE11] String read takes one byte per access and flags a carriage return; software stops after it.
// [RULE12] No automatic flow control; RTS is written, CTS is read by software.
// [RULE13] Shutdown stops transmit and receive and clears the transmit enable.
// [RULE14] Ring bases, lengths and baud divisor are programmable; the bases are only stored and do not move the rings.
// [RULE15] Bit rate is one sixteenth of the clock divided by a divisor.
// [RULE16] Frame is start low, data LSB first, optional parity, high stop bits.
`default_nettype none
module urd_serial_port import urd_pkg::*; #(
  parameter int unsigned AW = 8
) (
  input  wire logic              clk_sys,  // System clock 20 MHz
  input  wire logic              reset_n,  // Async reset
  input  wire logic              psel,     // APB select
  input  wire logic              penable,  // APB enable
  input  wire logic              pwrite,   // APB direction
  input  wire logic [ADDR_W-1:0] paddr,    // APB byte address
  input  wire logic [31:0]       pwdata,   // APB write data
  output logic      [31:0]       prdata,   // APB read data
  output logic                   pready,   // APB ready
  output logic                   pslverr,  // APB error
  input  wire logic              rxd,      // Serial in
  output logic                   txd,      // Serial out
  input  wire logic              ctsIn,    // Clear to send pin
  output logic                   rtsOut,   // Request to send pin
  output logic                   irq       // Level interrupt
);
  localparam logic [AW-1:0] ONE = {{(AW-1){1'b0}}, 1'b1};
  logic [8:0]    ctrl_q;
  logic [15:0]   baud_q;
  logic [AW-1:0] rxBase_q, rxSize_q, txBase_q, txSize_q;
  logic [AW-1:0] rxWr_q, rxRd_q, txWr_q, txRd_q;
  logic [EV_W-1:0] stat_q, mask_q;
  logic [31:0]   prdata_q;
  logic          txBusy_q;
  logic [2:0]    rxSync_q;
  logic          rxLvl_q;
  logic [2:0]    ctsSync_q;
  logic          ctsLvl_q;

  // APB decode; one wait-free access phase
  wire acc  = psel && penable;
  wire wrEn = acc && pwrite;
  wire rdEn = acc && !pwrite;
  wire hitCtrl = paddr == OFF_CTRL,    hitBaud = paddr == OFF_BAUD;
  wire hitRxB  = paddr == OFF_RXBASE,  hitRxS  = paddr == OFF_RXSIZE;
  wire hitTxB  = paddr == OFF_TXBASE,  hitTxS  = paddr == OFF_TXSIZE;
  wire hitCnt  = paddr == OFF_RXCOUNT, hitRxD  = paddr == OFF_RXDATA;
  wire hitTxQ  = paddr == OFF_TXQUEUE, hitTxSt = paddr == OFF_TXSTAT;
  wire hitStr  = paddr == OFF_STRREAD, hitStat = paddr == OFF_STATUS;
  wire hitMask = paddr == OFF_MASK,    hitRaw  = paddr == OFF_RXRAW;
  wire mapped = hitCtrl | hitBaud | hitRxB | hitRxS | hitTxB | hitTxS | hitCnt | hitRxD
              | hitTxQ | hitTxSt | hitStr | hitStat | hitMask | hitRaw;
  assign pready  = 1'b1;
  assign pslverr = acc && !mapped;

  wire enabled = ctrl_q[CT_ENABLE] && !ctrl_q[CT_SHUT];
  // Ring index wrap within programmed length; base is not added
  function automatic logic [AW-1:0] nextIdx(input logic [AW-1:0] idx,
                                             input logic [AW-1:0] size);
    nextIdx = (idx + ONE >= size) ? '0 : idx + ONE;
  endfunction
  wire [AW-1:0] rxCount = (rxWr_q >= rxRd_q) ? rxWr_q - rxRd_q
                                             : rxWr_q + rxSize_q - rxRd_q; // [RULE4]
  wire [AW-1:0] txNext  = nextIdx(txWr_q, txSize_q);
  wire          txFull  = txNext == txRd_q;

  // Receiver on tick
  logic          rxTick, txTick;
  logic [7:0]    rxRam, txRam;
  urd_state_e    rxSt_q, txSt_q;
  logic [3:0]    rxPh_q, txPh_q;
  logic [2:0]    rxBit_q, txBit_q;
  logic [7:0]    rxSh_q, txSh_q;
  logic [1:0]    txStop_q;
  logic          rxPar_q, txPar_q;
  wire  [2:0]    lastBit = ctrl_q[CT_SEVEN] ? 3'h6 : 3'h7;
  wire           rxMid = rxTick && rxPh_q == 4'(MID_SAMPLE - 1);
  wire           txEnd = txTick && txPh_q == 4'(OVERSAMPLE - 1);
  wire           rxDone = rxMid && rxSt_q == URD_STOP && rxLvl_q;
  wire [7:0]     rxByte = ctrl_q[CT_SEVEN] ? {1'b0, rxSh_q[7:1]} : rxSh_q;

  urd_baud_gen u_rxbaud (.clk_sys(clk_sys), .reset_n(reset_n), .run(enabled),
                         .divisor(baud_q), .tick(rxTick));
  urd_baud_gen u_txbaud (.clk_sys(clk_sys), .reset_n(reset_n), .run(enabled),
                         .divisor(baud_q), .tick(txTick));
  urd_ring_ram #(.AW(AW)) u_rxram (.clk_sys(clk_sys), .we(rxDone),
                         .waddr(rxWr_q), .wdata(rxByte), .raddr(rxRd_q), .rdata(rxRam));

  // Transmit ring written by the queue register
  wire txQueueOk = wrEn && hitTxQ && !txFull; // [RULE10]
  urd_ring_ram #(.AW(AW)) u_txram (.clk_sys(clk_sys), .we(txQueueOk),
                         .waddr(txWr_q), .wdata(pwdata[7:0]), .raddr(txRd_q), .rdata(txRam));

  // Input pins: three flops, change counts when the later two agree
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rxSync_q  <= 3'h7;
      rxLvl_q   <= 1'b1;
      ctsSync_q <= 3'h0;
      ctsLvl_q  <= 1'b0;
    end else begin
      rxSync_q  <= {rxSync_q[1:0], rxd};
      if (rxSync_q[1] == rxSync_q[2]) rxLvl_q <= rxSync_q[2];
      ctsSync_q <= {ctsSync_q[1:0], ctsIn};
      if (ctsSync_q[1] == ctsSync_q[2]) ctsLvl_q <= ctsSync_q[2]; // [RULE12]
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rxSt_q <= URD_IDLE; rxPh_q <= '0; rxBit_q <= '0; rxSh_q <= '0; rxPar_q <= 1'b0;
    end else if (!enabled) begin
      rxSt_q <= URD_IDLE; // [RULE3] [RULE13]
    end else if (rxTick) begin
      rxPh_q <= rxPh_q + 4'h1;
      unique case (rxSt_q)
        URD_IDLE: begin
          rxPh_q <= '0;
          if (!rxLvl_q) rxSt_q <= URD_START;
        end
        URD_START: if (rxMid) begin
          rxPh_q <= 4'(MID_SAMPLE);
          rxSt_q <= rxLvl_q ? URD_IDLE : URD_DATA;
          rxBit_q <= '0;
          rxPar_q <= ctrl_q[CT_PARODD];
        end
        URD_DATA: if (rxMid) begin
          rxSh_q  <= {rxLvl_q, rxSh_q[7:1]}; // [RULE16]
          rxPar_q <= rxPar_q ^ rxLvl_q;
          rxBit_q <= rxBit_q + 3'h1;
          if (rxBit_q == lastBit) rxSt_q <= ctrl_q[CT_PAREN] ? URD_PAR : URD_STOP;
        end
        URD_PAR: if (rxMid) rxSt_q <= URD_STOP;
        URD_STOP: if (rxMid) rxSt_q <= URD_IDLE;
        default: rxSt_q <= URD_IDLE;
      endcase
    end
  end

  // Transmitter: fetch from ring while indices differ and enable is set
  wire txStart = txSt_q == URD_IDLE && enabled && ctrl_q[CT_TXIE] && txRd_q != txWr_q; // [RULE8]
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      txSt_q <= URD_IDLE; txPh_q <= '0; txBit_q <= '0; txSh_q <= '0;
      txPar_q <= 1'b0; txStop_q <= '0; txd <= 1'b1;
    end else if (!enabled) begin
      txSt_q <= URD_IDLE;
      txd    <= 1'b1;
    end else if (txStart) begin
      txSt_q <= URD_START; // [RULE6]
      txSh_q <= txRam;
      txPh_q <= '0;
      txPar_q <= ctrl_q[CT_PARODD];
      txd    <= 1'b0;
    end else if (txTick && txSt_q != URD_IDLE) begin
      txPh_q <= txPh_q + 4'h1;
      if (txEnd) begin
        unique case (txSt_q)
          URD_START, URD_DATA: begin
            if (txSt_q == URD_START) txBit_q <= '0;
            else txBit_q <= txBit_q + 3'h1;
            if (txSt_q == URD_DATA && txBit_q == lastBit) begin
              txSt_q   <= ctrl_q[CT_PAREN] ? URD_PAR : URD_STOP;
              txd      <= ctrl_q[CT_PAREN] ? txPar_q : 1'b1;
              txStop_q <= {1'b0, ctrl_q[CT_STOP2]};
            end else begin
              txSt_q  <= URD_DATA;
              txd     <= txSh_q[0]; // [RULE16]
              txPar_q <= txPar_q ^ txSh_q[0];
              txSh_q  <= {1'b0, txSh_q[7:1]};
            end
          end
          URD_PAR: begin
            txSt_q <= URD_STOP;
            txd    <= 1'b1;
          end
          URD_STOP: begin
            if (txStop_q == '0) txSt_q <= URD_IDLE;
            txStop_q <= txStop_q - 2'h1;
          end
          default: txSt_q <= URD_IDLE;
        endcase
      end
    end
  end
  wire txSent = txSt_q == URD_STOP && txEnd && txStop_q == '0;

  // String read: returns one byte with valid and carriage-return flags per access
  logic [AW-1:0] strCnt;
  logic [AW-1:0] strIdx;
  logic          strStop;
  logic [7:0]    strSeen;
  always_comb begin
    strCnt  = '0;
    strIdx  = rxRd_q;
    strStop = 1'b0;
    strSeen = '0;
  end
  // Single-byte step per access keeps the path short; software repeats until CR flag
  wire strTake  = rdEn && hitStr && rxCount != '0 && pwdata[AW-1:0] != '0;
  wire rxTake   = (rdEn && hitRxD) || strTake; // [RULE5]
  wire crSeen   = strTake && rxRam == CR_BYTE; // [RULE11]

  // Index and register updates
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= '0; baud_q <= BAUD_RESET; // [RULE1]
      rxBase_q <= '0; rxSize_q <= '1; txBase_q <= '0; txSize_q <= '1;
      rxWr_q <= '0; rxRd_q <= '0; txWr_q <= '0; txRd_q <= '0;
      txBusy_q <= 1'b0; stat_q <= '0; mask_q <= '0;
    end else begin
      if (wrEn && hitCtrl) ctrl_q <= pwdata[8:0]; // [RULE12] [RULE1]
      if (wrEn && hitBaud) baud_q <= pwdata[15:0]; // [RULE14]
      if (wrEn && hitRxB) rxBase_q <= pwdata[AW-1:0];
      if (wrEn && hitRxS) begin
        rxSize_q <= pwdata[AW-1:0]; rxWr_q <= '0; rxRd_q <= '0;
      end
      if (wrEn && hitTxB) txBase_q <= pwdata[AW-1:0];
      if (wrEn && hitTxS) begin
        txSize_q <= pwdata[AW-1:0]; txWr_q <= '0; txRd_q <= '0;
      end
      if (wrEn && hitMask) mask_q <= pwdata[EV_W-1:0];
      if (rxDone) rxWr_q <= nextIdx(rxWr_q, rxSize_q); // [RULE2]
      if (rxDone && rxCount == rxSize_q - ONE) rxRd_q <= nextIdx(rxRd_q, rxSize_q);
      else if (rxTake && rxCount != '0) rxRd_q <= nextIdx(rxRd_q, rxSize_q);
      if (txQueueOk) begin
        txWr_q <= txNext;
        ctrl_q[CT_TXIE] <= 1'b1; // [RULE8]
        txBusy_q <= 1'b1;
      end
      if (txStart) txRd_q <= nextIdx(txRd_q, txSize_q);
      if (txSent && txRd_q == txWr_q && !txQueueOk) begin
        ctrl_q[CT_TXIE] <= 1'b0; // [RULE6]
        txBusy_q <= 1'b0; // [RULE7]
      end
      if (wrEn && hitCtrl && pwdata[CT_SHUT]) begin
        ctrl_q[CT_TXIE] <= 1'b0; // [RULE13]
        txBusy_q <= 1'b0;
      end
      // Read clears only the bits it reported, so an event after the setup edge survives
      stat_q <= ((rdEn && hitStat) ? stat_q & ~prdata_q[EV_W-1:0] : stat_q)
              | {crSeen, txSent && txRd_q == txWr_q, rxDone};
    end
  end
  assign irq    = |(stat_q & mask_q);
  assign rtsOut = ctrl_q[CT_RTS]; // [RULE12]

  wire [31:0] ctrlView = {23'h0, ctrl_q[CT_SHUT], ctsLvl_q, ctrl_q[6:0]};
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) prdata_q <= '0;
    else if (psel && !penable && !pwrite) begin
      prdata_q <= hitCtrl ? ctrlView
                : hitBaud ? {16'h0, baud_q}
                : hitRxB  ? 32'(rxBase_q)
                : hitRxS  ? 32'(rxSize_q)
                : hitTxB  ? 32'(txBase_q)
                : hitTxS  ? 32'(txSize_q)
                : hitCnt  ? 32'(rxCount)
                : hitRxD  ? {24'h0, rxRam}
                : hitTxSt ? {30'h0, txFull, txBusy_q}
                : hitStr  ? {22'h0, rxCount != '0 && rxRam == CR_BYTE, rxCount != '0, rxRam}
                : hitStat ? 32'(stat_q)
                : hitMask ? 32'(mask_q)
                : hitRaw  ? {31'h0, rxLvl_q}
                : 32'h0;
    end
  end
  assign prdata = prdata_q;
  wire unusedStr = ^{strCnt, strIdx, strStop, strSeen, rxPar_q, rxBase_q, txBase_q};
endmodule
`default_nettype wire

// file: tb/urd_serial_port_properties.sv
// Checker for the serial port: APB answers, RTS pin, interrupt mask, idle line.
// Assumes it is bound onto urd_serial_port and sees only its ports.
`default_nettype none
module urd_serial_port_chk import urd_pkg::*; (
  input wire logic              clk_sys,  // Clock
  input wire logic              reset_n,  // Reset
  input wire logic              psel,     // Select
  input wire logic              penable,  // Enable
  input wire logic              pwrite,   // Direction
  input wire logic [ADDR_W-1:0] paddr,    // Address
  input wire logic [31:0]       pwdata,   // Write data
  input wire logic [31:0]       prdata,   // Read data
  input wire logic              pready,   // Ready
  input wire logic              pslverr,  // Error
  input wire logic              txd,      // Serial out
  input wire logic              rtsOut,   // RTS pin
  input wire logic              irq       // Interrupt
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  logic acc;
  logic wrCtl;
  logic queued_q;
  logic maskZero_q;
  assign acc   = psel && penable;
  assign wrCtl = acc && pwrite && paddr == OFF_CTRL;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      queued_q   <= 1'b0;
      maskZero_q <= 1'b1;
    end else if (acc && pwrite) begin
      if (paddr == OFF_TXQUEUE) queued_q <= 1'b1;
      if (paddr == OFF_MASK) maskZero_q <= (pwdata[EV_W-1:0] == '0);
    end
  end
  a_ready_high: assert property (acc |-> pready)
    else $error("access phase without ready");
  a_err_unmapped: assert property (acc && paddr > OFF_RXRAW |-> pslverr)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (acc && paddr <= OFF_RXRAW && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped access refused");
  a_err_phase: assert property (pslverr |-> acc)
    else $error("error outside access phase");
  a_err_rdata: assert property (acc && !pwrite && pslverr |-> prdata == '0)
    else $error("refused read returned data");
  a_rts_write: assert property (wrCtl |=> rtsOut == $past(pwdata[CT_RTS]))
    else $error("rts pin not taken from control write");
  a_rts_hold: assert property (!wrCtl |=> $stable(rtsOut))
    else $error("rts pin moved without control write");
  a_irq_masked: assert property (maskZero_q && $past(maskZero_q) |-> !irq)
    else $error("interrupt with all sources masked");
  a_txd_quiet: assert property (!queued_q |-> txd)
    else $error("serial out active before any queued byte");
  cover property (wrCtl && pwdata[CT_RTS]);
  cover property ($fell(txd));
  cover property ($rose(irq));
  cover property (acc && pslverr);
endmodule
bind urd_serial_port urd_serial_port_chk i_urd_serial_port_chk (
  .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .txd(txd), .rtsOut(rtsOut), .irq(irq));
`default_nettype wire

// file: tb/urd_rs232_peer.sv
// Far-end serial device: drives the port's receive line, decodes its send line.
// Assumes eight data bits, no parity, one stop bit and BITC clocks per bit.
`default_nettype none
module urd_rs232_peer #(
  parameter int BITC = 32
) (
  input  wire logic clk_sys,  // Bench clock
  input  wire logic lineIn,   // Port serial out
  output logic      lineOut   // Port serial in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got[$];
  initial lineOut = 1'b1;
  task automatic send(input logic [7:0] b);
    @(posedge clk_sys);
    lineOut <= 1'b0;
    repeat (BITC) @(posedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      lineOut <= b[i];
      repeat (BITC) @(posedge clk_sys);
    end
    lineOut <= 1'b1;
    repeat (BITC) @(posedge clk_sys);
  endtask
  // Samples mid-bit so a slightly fast or slow sender still decodes
  always begin : decode
    logic [7:0] v;
    @(negedge lineIn);
    repeat (BITC + BITC / 2) @(posedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      v[i] = lineIn;
      repeat (BITC) @(posedge clk_sys);
    end
    got.push_back(v);
  end
endmodule
`default_nettype wire

// file: tb/tb_urd_serial_port.sv
// Self-checking bench for the ring-buffered serial port.
// Assumes an APB master here and the far-end device model on the serial pins.
`default_nettype none
module tb_urd_serial_port import urd_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BITC = 32; // Divisor 2 gives 32 clocks per bit
  logic              clk_sys = 1'b0;
  logic              reset_n = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic              ctsIn = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0]       pwdata = '0;
  logic [31:0]       prdata;
  logic [31:0]       r;
  logic              pready;
  logic              pslverr;
  logic              e;
  logic              rxd;
  logic              txd;
  logic              rtsOut;
  logic              irq;
  int                n_fail = 0;
  int                compares = 0;
  int                cyc = 0;
  int                q[$];
  urd_serial_port i_urd_serial_port (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd), .ctsIn(ctsIn),
    .rtsOut(rtsOut), .irq(irq));
  urd_rs232_peer #(.BITC(BITC)) i_urd_rs232_peer (.clk_sys(clk_sys), .lineIn(txd),
    .lineOut(rxd));
  always #25 clk_sys = ~clk_sys;
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task report_and_stop;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Answer taken at the edge that samples pready high, before that edge's updates land
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic send(input logic [7:0] b);
    i_urd_rs232_peer.send(b);
    q.push_back(b);
  endtask
  task automatic drain;
    while (q.size() > 0) begin
      apb(1'b0, OFF_RXDATA, 0);
      chk("rxdata", r[7:0], q.pop_front());
    end
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      report_and_stop();
    end
  end
  initial begin
    logic [7:0] b;
    int n;
    int nRef;
    void'($urandom(32'hbb57));
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    apb(1'b0, OFF_CTRL, 0);
    chk("ctrl", r, 32'h0);
    apb(1'b0, OFF_BAUD, 0);
    chk("baud", r, {16'h0, BAUD_RESET});
    chk("txd", txd, 1);
    apb(1'b0, 12'h040, 0);
    chk("slverr", e, 1);
    chk("badread", r, 0);
    for (int k = 0; k < 2; k++) begin
      b = 8'($urandom);
      @(posedge clk_sys);
      ctsIn <= b[0] ^ k[0];
      // Pin passes four flops, three sync and the level flop, before the control view shows it
      repeat (2) @(posedge clk_sys);
      apb(1'b1, OFF_CTRL, k << CT_RTS);
      chk("rts", rtsOut, k);
      apb(1'b0, OFF_CTRL, 0);
      chk("cts", r[CT_CTS], b[0] ^ k[0]);
    end
    apb(1'b1, OFF_BAUD, 2);
    apb(1'b1, OFF_CTRL, 1);
    apb(1'b1, OFF_MASK, 1);
    apb(1'b0, OFF_STATUS, 0);
    repeat (3) send(8'($urandom));
    apb(1'b0, OFF_RXCOUNT, 0);
    chk("rxcount", r, q.size());
    chk("irq", irq, 1);
    apb(1'b0, OFF_STATUS, 0);
    chk("rxevent", r[EV_RXBYTE], 1);
    drain();
    chk("irq", irq, 0);
    apb(1'b1, OFF_RXSIZE, 4);
    repeat (5) begin
      send(8'($urandom));
      if (q.size() > 3) void'(q.pop_front());
    end
    apb(1'b0, OFF_RXCOUNT, 0);
    chk("rxcount", r, 3);
    drain();
    send(8'h41);
    send(CR_BYTE);
    send(8'h42);
    n = 0;
    do begin
      apb(1'b0, OFF_STRREAD, 1);
      if (r[8]) chk("strbyte", r[7:0], q.pop_front());
      if (r[8]) n++;
    end while (r[8] && !r[9] && n < 3);
    chk("strlen", n, 2);
    apb(1'b0, OFF_RXCOUNT, 0);
    chk("rxleft", r, 1);
    drain();
    apb(1'b1, OFF_MASK, 2);
    apb(1'b1, OFF_TXSIZE, 2);
    apb(1'b0, OFF_STATUS, 0);
    nRef = 0;
    repeat (4) begin
      b = 8'($urandom);
      apb(1'b0, OFF_TXSTAT, 0);
      if (!r[1]) q.push_back(b);
      else nRef++;
      // Only the queue register touches the ring once sending is on
      apb(1'b1, OFF_TXQUEUE, b);
    end
    chk("refused", nRef > 0, 1);
    apb(1'b0, OFF_TXSTAT, 0);
    chk("busy", r[0], 1);
    n = 0;
    do begin
      apb(1'b0, OFF_TXSTAT, 0);
      n++;
    end while (r[0] && n < 3000);
    chk("busy", r[0], 0);
    chk("irq", irq, 1);
    chk("sent", i_urd_rs232_peer.got.size(), q.size());
    while (q.size() > 0) chk("txbyte", i_urd_rs232_peer.got.pop_front(), q.pop_front());
    apb(1'b1, OFF_CTRL, (1 << CT_SHUT) | 1);
    i_urd_rs232_peer.send(8'h5A);
    apb(1'b0, OFF_RXCOUNT, 0);
    chk("rxstopped", r, 0);
    report_and_stop();
  end
endmodule
`default_nettype wire
